// file: rtl/ccel_defs.svh
`ifndef CCEL_DEFS_SVH
`define CCEL_DEFS_SVH

// ----------------------------------------
// Channel set
// ----------------------------------------
`define CCEL_NCH 5
`define CCEL_AMP_CAPABLE 5'h17
`define CCEL_CMP_ONLY_CH 3

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define CCEL_OFF_STATUS 12'h000
`define CCEL_OFF_CTRL_FIRST 12'h004
`define CCEL_OFF_CTRL_LAST 12'h014
`define CCEL_OFF_IRQ_STAT 12'h018
`define CCEL_OFF_IRQ_MASK 12'h01C

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define CCEL_CTRL_EN 15
`define CCEL_CTRL_OE 14
`define CCEL_CTRL_POL 13
`define CCEL_CTRL_AMP 10
`define CCEL_CTRL_EVT 9
`define CCEL_CTRL_RES 8
`define CCEL_CTRL_EVS_HI 7
`define CCEL_CTRL_EVS_LO 6
`define CCEL_CTRL_WMASK 16'hE6D3
`define CCEL_CTRL_WMASK_CMP 16'hE2D3
`define CCEL_CTRL_RST 16'h0000

// ----------------------------------------
// Status register fields and resets
// ----------------------------------------
`define CCEL_STAT_HALT 15
`define CCEL_STAT_EVT_LO 8
`define CCEL_STAT_RES_LO 0
`define CCEL_IRQ_MASK_RST 5'h00

`endif

// file: rtl/ccel_pkg.sv
package ccel_pkg;

    typedef enum logic [1:0] {
        CCEL_EVS_OFF  = 2'h0,
        CCEL_EVS_RISE = 2'h1,
        CCEL_EVS_FALL = 2'h2,
        CCEL_EVS_ANY  = 2'h3
    } ccel_evs_t;

    typedef struct packed {
        logic [4:0] s1;
        logic [4:0] s2;
        logic [4:0] s3;
        logic [4:0] stable;
    } ccel_sync_st_t;

    typedef struct packed {
        logic [4:0] prev;
    } ccel_edge_st_t;

    typedef struct packed {
        logic [4:0][15:0] ctrl;
        logic halt;
        logic [4:0] irq_stat;
        logic [4:0] irq_mask;
        logic [4:0] trig;
        logic [4:0] pin;
        logic [31:0] rdata;
        logic err;
    } ccel_top_st_t;

endpackage

// file: rtl/ccel_sync.sv
`include "ccel_defs.svh"

module ccel_sync import ccel_pkg::*; (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [4:0] async_in,
    output logic [4:0] sync_out
);

    ccel_sync_st_t st_ff;
    ccel_sync_st_t nxt_st;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.s1 = async_in;
        nxt_st.s2 = st_ff.s1;
        nxt_st.s3 = st_ff.s2;
        for (int i = 0; i < `CCEL_NCH; i++) begin
            if (st_ff.s2[i] == st_ff.s3[i]) begin
                nxt_st.stable[i] = st_ff.s3[i];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign sync_out = st_ff.stable;

    AST_SYNC_AGREE: assert property (@(posedge pclk) disable iff (!presetn)
        ((sync_out ^ $past(sync_out)) & ($past(st_ff.s2) ^ $past(st_ff.s3))) == 5'h00)
        else $error("synchronised level moved while stages disagreed");

endmodule

// file: rtl/ccel_edge.sv
`include "ccel_defs.svh"

module ccel_edge import ccel_pkg::*; (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [4:0] level,
    input wire logic [4:0] enable,
    input wire logic [9:0] sel,
    input wire logic [4:0] flag,
    output logic [4:0] pulse
);

    ccel_edge_st_t st_ff;
    ccel_edge_st_t nxt_st;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.prev = level;
        pulse = 5'h00;
        for (int i = 0; i < `CCEL_NCH; i++) begin
            unique case (ccel_evs_t'(sel[2*i +: 2]))
                CCEL_EVS_RISE: pulse[i] = level[i] & ~st_ff.prev[i];
                CCEL_EVS_FALL: pulse[i] = ~level[i] & st_ff.prev[i];
                CCEL_EVS_ANY: pulse[i] = level[i] ^ st_ff.prev[i];
                CCEL_EVS_OFF: pulse[i] = 1'b0;
            endcase
            pulse[i] = pulse[i] & enable[i] & ~flag[i];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    AST_EVS_OFF: assert property (@(posedge pclk) disable iff (!presetn)
        (sel[1:0] == 2'h0) |-> !pulse[0])
        else $error("event raised with event select off");

    AST_FLAG_BLOCK: assert property (@(posedge pclk) disable iff (!presetn)
        flag[0] |-> !pulse[0])
        else $error("event raised while flag set");

    AST_RISE_SEEN: assert property (@(posedge pclk) disable iff (!presetn)
        (enable[0] && !flag[0] && sel[1:0] == 2'h1 && !level[0]) ##1
        (level[0] && enable[0] && !flag[0] && sel[1:0] == 2'h1) |-> pulse[0])
        else $error("rising edge missed");

endmodule

// file: rtl/ccel_top.sv
`include "ccel_defs.svh"

module ccel_top import ccel_pkg::*; (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic idle_mode,
    input wire logic [4:0] cmp_raw,
    output logic [4:0] channel_run,
    output logic [4:0] amplifier_select,
    output logic [4:0] result_pin,
    output logic [4:0] result_pin_oe,
    output logic [4:0] cmp_trigger,
    output logic irq
);

    ccel_top_st_t st_ff;
    ccel_top_st_t nxt_st;

    logic [4:0] sync_v;
    logic [4:0] res_v;
    logic [4:0] en_v;
    logic [4:0] oe_v;
    logic [4:0] pol_v;
    logic [4:0] amp_v;
    logic [4:0] evt_v;
    logic [9:0] sel_v;
    logic [4:0] pulse_v;
    logic halted;
    logic setup;
    logic wr;
    logic rd_acc;
    localparam logic [4:0] amp_cap_mask = `CCEL_AMP_CAPABLE;

    // ----------------------------------------
    // Address decode helpers
    // ----------------------------------------
    function automatic logic is_ctrl(input logic [11:0] a);
        return (a >= `CCEL_OFF_CTRL_FIRST) && (a <= `CCEL_OFF_CTRL_LAST) && (a[1:0] == 2'h0);
    endfunction

    function automatic logic [2:0] ctrl_idx(input logic [11:0] a);
        logic [11:0] d;
        d = a - `CCEL_OFF_CTRL_FIRST;
        return d[4:2];
    endfunction

    function automatic logic addr_ok(input logic [11:0] a);
        return is_ctrl(a) || (a == `CCEL_OFF_STATUS) || (a == `CCEL_OFF_IRQ_STAT)
            || (a == `CCEL_OFF_IRQ_MASK);
    endfunction

    function automatic logic [15:0] ctrl_word(input logic [2:0] i);
        logic [15:0] w;
        w = st_ff.ctrl[i];
        w[`CCEL_CTRL_RES] = res_v[i];
        return w;
    endfunction

    function automatic logic [31:0] read_word(input logic [11:0] a);
        logic [31:0] r;
        r = 32'h0000_0000;
        if (is_ctrl(a)) begin
            r[15:0] = ctrl_word(ctrl_idx(a));
        end else if (a == `CCEL_OFF_STATUS) begin
            r[`CCEL_STAT_HALT] = st_ff.halt;
            r[`CCEL_STAT_EVT_LO +: 5] = evt_v;
            r[`CCEL_STAT_RES_LO +: 5] = res_v;
        end else if (a == `CCEL_OFF_IRQ_STAT) begin
            r[4:0] = st_ff.irq_stat;
        end else if (a == `CCEL_OFF_IRQ_MASK) begin
            r[4:0] = st_ff.irq_mask;
        end
        return r;
    endfunction

    // ----------------------------------------
    // Comparator front end
    // ----------------------------------------
    ccel_sync ccel_sync_i (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(cmp_raw),
        .sync_out(sync_v)
    );

    always_comb begin
        for (int i = 0; i < `CCEL_NCH; i++) begin
            en_v[i] = st_ff.ctrl[i][`CCEL_CTRL_EN];
            oe_v[i] = st_ff.ctrl[i][`CCEL_CTRL_OE];
            pol_v[i] = st_ff.ctrl[i][`CCEL_CTRL_POL];
            amp_v[i] = st_ff.ctrl[i][`CCEL_CTRL_AMP];
            evt_v[i] = st_ff.ctrl[i][`CCEL_CTRL_EVT];
            sel_v[2*i +: 2] = st_ff.ctrl[i][`CCEL_CTRL_EVS_HI:`CCEL_CTRL_EVS_LO];
        end
    end

    assign res_v = sync_v ^ pol_v;

    assign halted = st_ff.halt & idle_mode;

    assign channel_run = en_v & {5{~halted}};

    // Halted channels raise no events, so no stale edge on wake-up is blamed
    ccel_edge ccel_edge_i (
        .pclk(pclk),
        .presetn(presetn),
        .level(res_v),
        .enable(channel_run),
        .sel(sel_v),
        .flag(evt_v),
        .pulse(pulse_v)
    );

    // ----------------------------------------
    // Register file and APB slave
    // ----------------------------------------
    assign setup = psel & ~penable;
    assign wr = psel & penable & pwrite & ~st_ff.err;
    assign rd_acc = psel & penable & ~pwrite;

    always_comb begin
        logic [15:0] msk;
        logic [4:0] clr;
        msk = `CCEL_CTRL_WMASK;
        clr = 5'h00;
        nxt_st = st_ff;
        nxt_st.trig = pulse_v;
        nxt_st.pin = res_v & oe_v;

        // Read data is latched in setup so the access cycle answers at once
        if (setup) begin
            nxt_st.rdata = read_word(paddr);
            nxt_st.err = ~addr_ok(paddr);
        end

        if (wr) begin
            if (is_ctrl(paddr)) begin
                // amplifier bit only on capable channels
                if (!amp_cap_mask[ctrl_idx(paddr)]) begin
                    msk = `CCEL_CTRL_WMASK_CMP;
                end
                nxt_st.ctrl[ctrl_idx(paddr)] = pwdata[15:0] & msk;
            end else if (paddr == `CCEL_OFF_STATUS) begin
                nxt_st.halt = pwdata[`CCEL_STAT_HALT];
            end else if (paddr == `CCEL_OFF_IRQ_MASK) begin
                nxt_st.irq_mask = pwdata[4:0];
            end
        end

        // event sets flag, set beats clear
        for (int i = 0; i < `CCEL_NCH; i++) begin
            if (pulse_v[i]) begin
                nxt_st.ctrl[i][`CCEL_CTRL_EVT] = 1'b1;
            end
        end

        // Only bits returned by this read are cleared; later events survive
        if (rd_acc && !st_ff.err && paddr == `CCEL_OFF_IRQ_STAT) begin
            clr = st_ff.rdata[4:0];
        end
        nxt_st.irq_stat = (st_ff.irq_stat & ~clr) | pulse_v;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff.ctrl <= {5{`CCEL_CTRL_RST}};
            st_ff.halt <= 1'b0;
            st_ff.irq_stat <= 5'h00;
            st_ff.irq_mask <= `CCEL_IRQ_MASK_RST;
            st_ff.trig <= 5'h00;
            st_ff.pin <= 5'h00;
            st_ff.rdata <= 32'h0000_0000;
            st_ff.err <= 1'b0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign prdata = st_ff.rdata;
    assign pready = 1'b1;
    assign pslverr = psel & penable & st_ff.err;
    assign amplifier_select = amp_v;
    assign result_pin = st_ff.pin;
    assign result_pin_oe = oe_v;
    assign cmp_trigger = st_ff.trig;
    assign irq = |(st_ff.irq_stat & st_ff.irq_mask);

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    AST_CMP_ONLY: assert property (
        !amplifier_select[`CCEL_CMP_ONLY_CH])
        else $error("comparator-only channel in amplifier mode");

    AST_IDLE_HALT: assert property (
        (st_ff.halt && idle_mode) |-> (channel_run == 5'h00))
        else $error("channel running while halted in idle");

    AST_EVT_MIRROR: assert property (
        (setup && !pwrite && paddr == `CCEL_OFF_STATUS)
        |=> (prdata[12:8] == $past(evt_v)))
        else $error("status event copies wrong");

    AST_RES_MIRROR: assert property (
        (setup && !pwrite && paddr == `CCEL_OFF_STATUS)
        |=> (prdata[4:0] == $past(res_v)))
        else $error("status result copies wrong");

    AST_ENABLE: assert property (
        (wr && paddr == `CCEL_OFF_CTRL_FIRST && pwdata[15])
        |=> (channel_run[0] || idle_mode))
        else $error("enable write did not start channel");

    AST_PIN_INTERNAL: assert property (
        !oe_v[0] |=> !result_pin[0])
        else $error("pin driven while internal only");

    AST_AMP_WRITE: assert property (
        (wr && paddr == `CCEL_OFF_CTRL_FIRST)
        |=> (amplifier_select[0] == $past(pwdata[10])))
        else $error("amplifier select did not follow write");

    AST_FLAG_HOLD: assert property (
        (evt_v[0] && !(wr && paddr == `CCEL_OFF_CTRL_FIRST)) |=> evt_v[0])
        else $error("event flag dropped without clear");

    AST_FLAG_SET: assert property (
        pulse_v[0] |=> (evt_v[0] && cmp_trigger[0]))
        else $error("event did not set flag and trigger");

    AST_RES_POLARITY: assert property (
        (setup && !pwrite && paddr == `CCEL_OFF_CTRL_FIRST)
        |=> (prdata[8] == ($past(sync_v[0]) ^ $past(pol_v[0]))))
        else $error("result bit polarity wrong");

    AST_CTRL_GAP: assert property (
        (setup && !pwrite && is_ctrl(paddr)) |=> (prdata[12:11] == 2'h0))
        else $error("unimplemented control bits read nonzero");

    AST_IRQ_LEVEL: assert property (
        $past(pulse_v[0]) && st_ff.irq_mask[0] |-> irq)
        else $error("unmasked event gave no interrupt");

    AST_SET_WINS: assert property (
        (pulse_v[0] && wr && paddr == `CCEL_OFF_CTRL_FIRST && !pwdata[`CCEL_CTRL_EVT])
        |=> evt_v[0])
        else $error("event lost to a same-cycle flag clear");

    AST_TRIG_SINGLE: assert property (
        cmp_trigger[0] |=> !cmp_trigger[0])
        else $error("trigger stood longer than one cycle");

    AST_PIN_FOLLOWS: assert property (
        oe_v[0] |=> (result_pin[0] == $past(res_v[0])))
        else $error("pin does not carry the result");

    AST_STOPPED_QUIET: assert property (
        !channel_run[0] |-> !pulse_v[0])
        else $error("event from a stopped channel");

    AST_RUN_NO_HALT: assert property (
        !st_ff.halt |-> (channel_run == en_v))
        else $error("channel stopped without halt set");

    AST_STAT_RO: assert property (
        (wr && paddr == `CCEL_OFF_STATUS)
        |=> (evt_v == ($past(evt_v) | $past(pulse_v))))
        else $error("status write changed event flags");

endmodule

// file: verification/tb_ccel_top.sv
`include "ccel_defs.svh"
module tb_ccel_top import ccel_pkg::*; ;
    timeunit 1ns;
    timeprecision 100ps;
    // ----------------------------------------
    // Stimulus and observed signals
    // ----------------------------------------
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic idle_mode = 1'b0;
    logic [4:0] cmp_raw = 5'h00;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [4:0] channel_run;
    logic [4:0] amplifier_select;
    logic [4:0] result_pin;
    logic [4:0] result_pin_oe;
    logic [4:0] cmp_trigger;
    logic irq;
    int n_errors = 0;
    int cmp_count = 0;
    localparam logic [11:0] A_ST = `CCEL_OFF_STATUS;
    localparam logic [11:0] A_IS = `CCEL_OFF_IRQ_STAT;
    localparam logic [11:0] A_IM = `CCEL_OFF_IRQ_MASK;

    always #5 pclk = ~pclk;

    ccel_top ccel_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .idle_mode(idle_mode), .cmp_raw(cmp_raw),
        .channel_run(channel_run), .amplifier_select(amplifier_select),
        .result_pin(result_pin), .result_pin_oe(result_pin_oe),
        .cmp_trigger(cmp_trigger), .irq(irq));

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // Request held until pready is seen high; only the watchdog ends a hang
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, {16'h0000, d}, q, e);
    endtask

    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0000_0000, q, e);
        chk(q, exp);
    endtask

    function automatic logic [11:0] ctl(input int i);
        return `CCEL_OFF_CTRL_FIRST + 12'(4 * i);
    endfunction

    task automatic count_trig(input int ch, output int c);
        c = 0;
        repeat (12) begin
            @(posedge pclk);
            if (cmp_trigger[ch] === 1'b1) c++;
        end
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset;
        for (int i = 0; i < 5; i++) rdc(ctl(i), 32'h0000_0000);
        rdc(A_ST, 32'h0000_0000);
        rdc(A_IM, 32'h0000_0000);
        chk(32'(irq), 32'h0);
        chk(32'(channel_run), 32'h0);
        $display("test reset done");
    endtask

    task automatic t_fields;
        for (int i = 0; i < 5; i++) wr(ctl(i), 16'hFFFF);
        tick(6);
        // Inverted zero input reads back as result one
        for (int i = 0; i < 5; i++) rdc(ctl(i), 32'(((i == `CCEL_CMP_ONLY_CH) ?
            `CCEL_CTRL_WMASK_CMP : `CCEL_CTRL_WMASK) | 16'h0100));
        rdc(A_ST, 32'h0000_1F1F);
        chk(32'(amplifier_select), 32'(`CCEL_AMP_CAPABLE));
        chk(32'(result_pin_oe), 32'h1F);
        chk(32'(result_pin), 32'h1F);
        chk(32'(channel_run), 32'h1F);
        wr(A_ST, 16'h8000);
        idle_mode <= 1'b1;
        tick(2);
        chk(32'(channel_run), 32'h0);
        rdc(A_ST, 32'h0000_9F1F);
        idle_mode <= 1'b0;
        tick(2);
        chk(32'(channel_run), 32'h1F);
        wr(A_ST, 16'h0000);
        idle_mode <= 1'b1;
        tick(2);
        chk(32'(channel_run), 32'h1F);
        idle_mode <= 1'b0;
        for (int i = 0; i < 5; i++) wr(ctl(i), 16'h0000);
        cmp_raw <= 5'h1F;
        tick(8);
        rdc(A_ST, 32'h0000_001F);
        chk(32'(result_pin), 32'h0);
        chk(32'(amplifier_select), 32'h0);
        chk(32'(channel_run), 32'h0);
        cmp_raw <= 5'h00;
        tick(8);
        // Flag set together with polarity, so no event was recorded
        rdc(A_IS, 32'h0000_0000);
        $display("test fields done");
    endtask

    task automatic t_unmapped;
        logic [31:0] q;
        logic e;
        wr(12'h020, 16'h8000);
        apb(1'b0, 12'h020, 32'h0, q, e);
        chk(q, 32'h0);
        chk(32'(e), 32'h1);
        rdc(A_ST, 32'h0000_0000);
        $display("test unmapped done");
    endtask

    task automatic t_events;
        int c;
        logic m1;
        logic m2;
        logic [15:0] base;
        for (int s = 0; s < 4; s++) begin
            for (int p = 0; p < 2; p++) begin
                base = 16'h8000 | 16'(p << 13);
                wr(ctl(0), base);
                tick(8);
                wr(ctl(0), base | 16'(s << 6));
                tick(2);
                m1 = (s == 3) || (s == 1 && p == 0) || (s == 2 && p == 1);
                m2 = (s == 3) || (s == 1 && p == 1) || (s == 2 && p == 0);
                cmp_raw[0] <= 1'b1;
                count_trig(0, c);
                chk(32'(c), 32'(m1));
                rdc(ctl(0), 32'(base | 16'(s << 6) | (16'(m1) << 9) | 16'((p ^ 1) << 8)));
                cmp_raw[0] <= 1'b0;
                count_trig(0, c);
                chk(32'(c), 32'(!m1 && m2));
            end
        end
        // Disabled channel must stay silent
        wr(ctl(0), 16'h00C0);
        tick(8);
        cmp_raw[0] <= 1'b1;
        count_trig(0, c);
        chk(32'(c), 32'h0);
        cmp_raw[0] <= 1'b0;
        wr(ctl(0), 16'h0000);
        tick(8);
        // Channel zero events are sticky until this read
        rdc(A_IS, 32'h0000_0001);
        $display("test events done");
    endtask

    task automatic t_irq;
        wr(ctl(1), 16'h80C0);
        wr(ctl(2), 16'h80C0);
        tick(8);
        cmp_raw <= 5'h06;
        tick(12);
        chk(32'(irq), 32'h0);
        rdc(A_ST, 32'h0000_0606);
        wr(A_IM, 16'h0002);
        tick(1);
        chk(32'(irq), 32'h1);
        rdc(A_IS, 32'h0000_0006);
        tick(1);
        chk(32'(irq), 32'h0);
        rdc(A_IS, 32'h0000_0000);
        wr(ctl(1), 16'h0000);
        wr(ctl(2), 16'h0000);
        wr(A_IM, 16'h0000);
        cmp_raw <= 5'h00;
        $display("test irq done");
    endtask

    task automatic give_verdict;
        $display("Counts: %0d compares, %0d mismatches", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_fields();
        t_unmapped();
        t_events();
        t_irq();
        give_verdict();
    end

    // Full run needs well under 2000 cycles
    initial begin
        repeat (20000) @(posedge pclk);
        n_errors++;
        give_verdict();
    end
endmodule
